// ### design/ebpm_pkg.sv
package ebpm_pkg;
   localparam int unsigned CLK_PER_MC      = 4;
   localparam logic [1:0]  PHASE_LAST      = 2'h3;
   localparam logic [3:0]  STRETCH_MIN     = 4'h2;
   localparam logic [3:0]  STRETCH_MAX     = 4'h9;
   localparam logic [15:0] SRAM_TOP        = 16'h03ff;
   localparam int unsigned SRAM_DEPTH      = 1024;
   localparam logic [7:0]  PORT_RESET      = 8'hff;
   localparam logic [3:0]  PORT4_RESET     = 4'hf;
   localparam int unsigned P3_WR_BIT       = 6;
   localparam int unsigned P3_RD_BIT       = 7;

   typedef enum logic [1:0] {
      EBPM_KIND_FETCH = 2'h0,
      EBPM_KIND_MOVC  = 2'h1,
      EBPM_KIND_RDX   = 2'h2,
      EBPM_KIND_WRX   = 2'h3
   } ebpm_kind_t;

   typedef enum logic [4:0] {
      EBPM_IDLE  = 5'b00001,
      EBPM_ADDR  = 5'b00010,
      EBPM_DATA  = 5'b00100,
      EBPM_SRAM  = 5'b01000,
      EBPM_DONE  = 5'b10000
   } ebpm_state_t;
endpackage : ebpm_pkg

// ### design/ebpm_sram.sv
module ebpm_sram (
   input  wire logic       clk_sys,
   input  wire logic       we,
   input  wire logic [9:0] addr,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata
);
   logic [7:0] mem_q [ebpm_pkg::SRAM_DEPTH];
   logic [7:0] rdata_q;

   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem_q[addr] <= wdata;
      end
      rdata_q <= mem_q[addr];
   end

   assign rdata = rdata_q;
endmodule : ebpm_sram

// ### design/ebpm_port_mux.sv
module ebpm_port_mux (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // Core request side
   input  wire logic        req_valid,
   input  wire logic [1:0]  req_kind,
   input  wire logic [15:0] req_addr,
   input  wire logic [7:0]  req_wdata,
   output logic             req_done,
   output logic [7:0]       req_rdata,
   input  wire logic [3:0]  movx_stretch,
   input  wire logic        sram_enable_wr,
   input  wire logic        sram_enable_val,
   output logic             internal_sram_enable,
   input  wire logic        wait_enable,
   // Port latches written by software
   input  wire logic [7:0]  p0_latch,
   input  wire logic [7:0]  p1_latch,
   input  wire logic [7:0]  p2_latch,
   input  wire logic [7:0]  p3_latch,
   input  wire logic [3:0]  p4_latch,
   // Pins: out, enable (low drives), in
   input  wire logic [7:0]  p0_in,
   output logic [7:0]       p0_out,
   output logic [7:0]       p0_oe_n,
   input  wire logic [7:0]  p1_in,
   output logic [7:0]       p1_out,
   output logic [7:0]       p1_oe_n,
   input  wire logic [7:0]  p2_in,
   output logic [7:0]       p2_out,
   output logic [7:0]       p2_oe_n,
   input  wire logic [7:0]  p3_in,
   output logic [7:0]       p3_out,
   output logic [7:0]       p3_oe_n,
   input  wire logic [3:0]  p4_in,
   output logic [3:0]       p4_out,
   output logic [3:0]       p4_oe_n,
   output logic             address_latch_strobe,
   output logic             program_store_strobe,
   // Synchronised port pin levels and alternate inputs
   output logic [7:0]       p0_pins,
   output logic [7:0]       p1_pins,
   output logic [7:0]       p2_pins,
   output logic [7:0]       p3_pins,
   output logic [3:0]       p4_pins,
   output logic             timer2_count_in,
   output logic             timer2_reload_capture_in,
   output logic             serial_b_receive,
   output logic             ext_irq_two,
   output logic             ext_irq_three,
   output logic             ext_irq_four,
   output logic             ext_irq_five,
   output logic             serial_a_receive,
   output logic             ext_irq_zero,
   output logic             ext_irq_one,
   output logic             timer_zero_ext_in,
   output logic             timer_one_ext_in,
   output logic             wait_request,
   input  wire logic        serial_a_transmit,
   input  wire logic        serial_b_transmit
);
   // Two-stage synchronisers for every pin input
   logic [35:0] sync1_q, sync2_q;
   logic [35:0] sync1_d, sync2_d;

   always_comb begin
      sync1_d = {p4_in, p3_in, p2_in, p1_in, p0_in};
      sync2_d = sync1_q;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sync1_q <= '1;
         sync2_q <= '1;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
      end
   end

   ebpm_pkg::ebpm_state_t st_q, st_d;
   logic [1:0]      ph_q, ph_d;
   logic [3:0]      mc_q, mc_d;
   logic [3:0]      mc_len_q, mc_len_d;
   logic [1:0]      kind_q, kind_d;
   logic [15:0]     addr_q, addr_d;
   logic [7:0]      wdata_q, wdata_d;
   logic            sram_en_q, sram_en_d;
   logic            done_q, done_d;
   logic [7:0]      rdata_q, rdata_d;
   logic            sram_we;
   logic [7:0]      sram_rdata;
   logic            wait_hold;

   function automatic logic is_data(input logic [1:0] k);
      return k[1];
   endfunction : is_data

   // Clamp programmed length to two..nine machine cycles
   function automatic logic [3:0] clamp_len(input logic [3:0] v);
      if (v < ebpm_pkg::STRETCH_MIN) begin
         return ebpm_pkg::STRETCH_MIN;
      end
      if (v > ebpm_pkg::STRETCH_MAX) begin
         return ebpm_pkg::STRETCH_MAX;
      end
      return v;
   endfunction : clamp_len

   // Wait pin freezes the data phase count of MOVX accesses
   assign wait_hold = wait_enable & ~sync2_q[32] & (st_q == ebpm_pkg::EBPM_DATA) & is_data(kind_q);

   always_comb begin
      st_d      = st_q;
      ph_d      = ph_q;
      mc_d      = mc_q;
      mc_len_d  = mc_len_q;
      kind_d    = kind_q;
      addr_d    = addr_q;
      wdata_d   = wdata_q;
      done_d    = 1'b0;
      rdata_d   = rdata_q;
      sram_en_d = sram_en_q;
      sram_we   = 1'b0;
      if (sram_enable_wr) begin
         sram_en_d = sram_enable_val;
      end
      ph_d = (st_q == ebpm_pkg::EBPM_IDLE) ? 2'h0 : ph_q + 2'h1;
      unique case (st_q)
         ebpm_pkg::EBPM_IDLE: begin
            if (req_valid) begin
               kind_d   = req_kind;
               addr_d   = req_addr;
               wdata_d  = req_wdata;
               mc_d     = 4'h1;
               mc_len_d = is_data(req_kind) ? clamp_len(movx_stretch) : 4'h1;
               if (is_data(req_kind) && sram_en_q && req_addr <= ebpm_pkg::SRAM_TOP) begin
                  st_d = ebpm_pkg::EBPM_SRAM;
               end else begin
                  st_d = ebpm_pkg::EBPM_ADDR;
               end
            end
         end
         ebpm_pkg::EBPM_SRAM: begin
            sram_we = (kind_q == ebpm_pkg::EBPM_KIND_WRX) && (ph_q == 2'h0);
            if (ph_q == ebpm_pkg::PHASE_LAST) begin
               st_d    = ebpm_pkg::EBPM_DONE;
               rdata_d = sram_rdata;
            end
         end
         ebpm_pkg::EBPM_ADDR: begin
            if (ph_q == 2'h1) begin
               st_d = ebpm_pkg::EBPM_DATA;
               ph_d = 2'h0;
            end
         end
         ebpm_pkg::EBPM_DATA: begin
            if (wait_hold) begin
               ph_d = ph_q;
            end else if (ph_q == ebpm_pkg::PHASE_LAST) begin
               if (mc_q >= mc_len_q) begin
                  st_d    = ebpm_pkg::EBPM_DONE;
                  rdata_d = sync2_q[7:0];
               end else begin
                  mc_d = mc_q + 4'h1;
               end
            end
         end
         ebpm_pkg::EBPM_DONE: begin
            done_d = 1'b1;
            st_d   = ebpm_pkg::EBPM_IDLE;
         end
         default: st_d = ebpm_pkg::EBPM_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q      <= ebpm_pkg::EBPM_IDLE;
         ph_q      <= 2'h0;
         mc_q      <= 4'h0;
         mc_len_q  <= 4'h1;
         kind_q    <= 2'h0;
         addr_q    <= 16'h0000;
         wdata_q   <= 8'h00;
         sram_en_q <= 1'b0;
         done_q    <= 1'b0;
         rdata_q   <= 8'h00;
      end else begin
         st_q      <= st_d;
         ph_q      <= ph_d;
         mc_q      <= mc_d;
         mc_len_q  <= mc_len_d;
         kind_q    <= kind_d;
         addr_q    <= addr_d;
         wdata_q   <= wdata_d;
         sram_en_q <= sram_en_d;
         done_q    <= done_d;
         rdata_q   <= rdata_d;
      end
   end

   ebpm_sram u_sram (
      .clk_sys (clk_sys),
      .we      (sram_we),
      .addr    (addr_q[9:0]),
      .wdata   (wdata_q),
      .rdata   (sram_rdata)
   );

   // Registered pin drive
   logic [7:0] p0o_d, p0e_d, p1o_d, p1e_d, p2o_d, p2e_d, p3o_d, p3e_d;
   logic [3:0] p4o_d, p4e_d;
   logic       ale_d, program_store_strobe_d, wreq_d;
   logic [7:0] p0o_q, p0e_q, p1o_q, p1e_q, p2o_q, p2e_q, p3o_q, p3e_q;
   logic [3:0] p4o_q, p4e_q;
   logic       ale_q, program_store_strobe_q, wreq_q;
   logic       ext_bus;

   assign ext_bus = (st_d == ebpm_pkg::EBPM_ADDR) || (st_d == ebpm_pkg::EBPM_DATA);

   always_comb begin
      // open drain: enable only to pull low
      p0o_d  = 8'h00;
      p0e_d  = p0_latch;
      p1o_d  = 8'h00;
      p1e_d  = {p1_latch[7:4], serial_b_transmit & p1_latch[3], p1_latch[2:0]};
      p2o_d  = 8'h00;
      p2e_d  = p2_latch;
      p3o_d  = 8'h00;
      p3e_d  = {p3_latch[7:2], serial_a_transmit & p3_latch[1], p3_latch[0]};
      p4o_d  = 4'h0;
      p4e_d  = p4_latch;
      if (wait_enable) begin
         p4e_d[0] = 1'b1;
      end
      ale_d  = 1'b0;
      program_store_strobe_d = 1'b1;
      wreq_d = wait_enable & ~sync2_q[32];
      if (ext_bus) begin
         p2o_d = addr_d[15:8];
         p2e_d = 8'h00;
         if (st_d == ebpm_pkg::EBPM_ADDR) begin
            p0o_d = addr_d[7:0];
            p0e_d = 8'h00;
            ale_d = 1'b1;
         end else if (kind_d == ebpm_pkg::EBPM_KIND_WRX) begin
            p0o_d = wdata_d;
            p0e_d = 8'h00;
            p3e_d[ebpm_pkg::P3_WR_BIT] = 1'b0;
         end else begin
            p0e_d = 8'hff;
            if (kind_d == ebpm_pkg::EBPM_KIND_RDX) begin
               p3e_d[ebpm_pkg::P3_RD_BIT] = 1'b0;
            end else begin
               program_store_strobe_d = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         p0o_q  <= 8'h00;
         p0e_q  <= ebpm_pkg::PORT_RESET;
         p1o_q  <= 8'h00;
         p1e_q  <= ebpm_pkg::PORT_RESET;
         p2o_q  <= 8'h00;
         p2e_q  <= ebpm_pkg::PORT_RESET;
         p3o_q  <= 8'h00;
         p3e_q  <= ebpm_pkg::PORT_RESET;
         p4o_q  <= 4'h0;
         p4e_q  <= ebpm_pkg::PORT4_RESET;
         ale_q  <= 1'b0;
         program_store_strobe_q <= 1'b1;
         wreq_q <= 1'b0;
      end else begin
         p0o_q  <= p0o_d;
         p0e_q  <= p0e_d;
         p1o_q  <= p1o_d;
         p1e_q  <= p1e_d;
         p2o_q  <= p2o_d;
         p2e_q  <= p2e_d;
         p3o_q  <= p3o_d;
         p3e_q  <= p3e_d;
         p4o_q  <= p4o_d;
         p4e_q  <= p4e_d;
         ale_q  <= ale_d;
         program_store_strobe_q <= program_store_strobe_d;
         wreq_q <= wreq_d;
      end
   end

   assign p0_out               = p0o_q;
   assign p0_oe_n              = p0e_q;
   assign p1_out               = p1o_q;
   assign p1_oe_n              = p1e_q;
   assign p2_out               = p2o_q;
   assign p2_oe_n              = p2e_q;
   assign p3_out               = p3o_q;
   assign p3_oe_n              = p3e_q;
   assign p4_out               = p4o_q;
   assign p4_oe_n              = p4e_q;
   assign address_latch_strobe = ale_q;
   assign program_store_strobe = program_store_strobe_q;
   assign req_done             = done_q;
   assign req_rdata            = rdata_q;
   assign internal_sram_enable = sram_en_q;

   assign p0_pins                  = sync2_q[7:0];
   assign p1_pins                  = sync2_q[15:8];
   assign p2_pins                  = sync2_q[23:16];
   assign p3_pins                  = sync2_q[31:24];
   assign p4_pins                  = sync2_q[35:32];
   assign timer2_count_in          = sync2_q[8];
   assign timer2_reload_capture_in = sync2_q[9];
   assign serial_b_receive         = sync2_q[10];
   assign ext_irq_two              = sync2_q[12];
   assign ext_irq_three            = sync2_q[13];
   assign ext_irq_four             = sync2_q[14];
   assign ext_irq_five             = sync2_q[15];
   assign serial_a_receive         = sync2_q[24];
   assign ext_irq_zero             = sync2_q[26];
   assign ext_irq_one              = sync2_q[27];
   assign timer_zero_ext_in        = sync2_q[28];
   assign timer_one_ext_in         = sync2_q[29];
   assign wait_request             = wreq_q;
endmodule : ebpm_port_mux

// ### testbench/ebpm_port_mux_sva.sv
module ebpm_port_mux_chk (
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       req_done,
   input wire logic       sram_enable_wr,
   input wire logic       sram_enable_val,
   input wire logic       internal_sram_enable,
   input wire logic       wait_enable,
   input wire logic       wait_request,
   input wire logic [7:0] p3_latch,
   input wire logic       serial_a_transmit,
   input wire logic [7:0] p0_oe_n,
   input wire logic [7:0] p2_oe_n,
   input wire logic [7:0] p3_oe_n,
   input wire logic [3:0] p4_oe_n,
   input wire logic       address_latch_strobe,
   input wire logic       program_store_strobe,
   input wire logic [7:0] p1_in,
   input wire logic [7:0] p3_in,
   input wire logic       timer2_count_in,
   input wire logic       ext_irq_five,
   input wire logic       serial_a_receive,
   input wire logic       timer_one_ext_in
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   AST_P0_BUS: assert property (address_latch_strobe |-> p0_oe_n == 8'h00)
      else $error("port 0 not driven in address phase");
   AST_P2_BUS: assert property (address_latch_strobe |-> p2_oe_n == 8'h00)
      else $error("port 2 not driven in address phase");
   AST_ALE_WIDTH: assert property ($rose(address_latch_strobe) |-> address_latch_strobe [*2] ##1 !address_latch_strobe)
      else $error("address strobe width wrong");
   AST_WR_DATA: assert property (p3_latch[6] && !p3_oe_n[6] |-> p0_oe_n == 8'h00 && !address_latch_strobe)
      else $error("write strobe without data drive");
   AST_PROGRAM_STORE_STROBE_MOVX: assert property (p3_latch[7:6] == 2'h3 && !program_store_strobe |-> p3_oe_n[7:6] == 2'h3)
      else $error("code strobe overlaps data strobe");
   AST_DONE_PULSE: assert property (req_done |=> !req_done)
      else $error("done longer than one cycle");
   AST_SRAM_EN: assert property (sram_enable_wr |=> internal_sram_enable == $past(sram_enable_val))
      else $error("sram enable not written");
   AST_WAIT_PIN: assert property (wait_enable && $past(wait_enable) |-> p4_oe_n[0])
      else $error("wait pin driven while enabled");
   AST_WAIT_REQ: assert property (wait_request |-> $past(wait_enable))
      else $error("wait request while disabled");
   AST_ALT_SYNC: assert property (!$past(rst) && !$past(rst, 2) |->
      {timer2_count_in, ext_irq_five, serial_a_receive, timer_one_ext_in} ==
      {$past(p1_in[0], 2), $past(p1_in[7], 2), $past(p3_in[0], 2), $past(p3_in[5], 2)})
      else $error("alternate input not two-stage pin level");
   AST_TXD_GATE: assert property (!$past(rst) |-> p3_oe_n[1] == $past(p3_latch[1] & serial_a_transmit))
      else $error("serial transmit pin drive wrong");
endmodule : ebpm_port_mux_chk
bind ebpm_port_mux ebpm_port_mux_chk u_ebpm_port_mux_chk (.*);

// ### testbench/ebpm_ext_mem.sv
module ebpm_ext_mem (
   input  wire logic       clk_sys,
   input  wire logic [7:0] p0_out,
   input  wire logic [7:0] p0_oe_n,
   input  wire logic [7:0] p2_in,
   input  wire logic [7:0] p3_oe_n,
   input  wire logic       address_latch_strobe,
   input  wire logic       program_store_strobe,
   output logic      [7:0] p0_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]  mem [0:65535];
   logic [15:0] addr_q;
   logic [7:0]  last_q;
   logic        rd_act;
   assign rd_act = !p3_oe_n[7] | !program_store_strobe;
   assign p0_in = (~p0_oe_n & p0_out) | (p0_oe_n & (rd_act ? mem[addr_q] : ~last_q));
   always @(posedge clk_sys) begin
      last_q <= p0_in;
      if (address_latch_strobe)
         addr_q <= {p2_in, p0_in};
      if (!p3_oe_n[6])
         mem[addr_q] <= p0_in;
   end
endmodule : ebpm_ext_mem

// ### testbench/test_external_bus_port_mux.sv
module test_external_bus_port_mux;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
   logic clk_sys = 1'b0, rst = 1'b1, req_valid = 1'b0, sram_enable_wr = 1'b0, sram_enable_val = 1'b0;
   logic wait_enable = 1'b0, wait_low = 1'b0, serial_a_transmit = 1'b1, serial_b_transmit = 1'b1;
   logic [1:0] req_kind = 2'h0;
   logic [15:0] req_addr = 16'h0000;
   logic [7:0] req_wdata = 8'h00, p1_latch = 8'hff, p1_in, p2_in, p3_in, p0_in;
   logic [3:0] movx_stretch = 4'h2, p4_in;
   logic req_done, internal_sram_enable, address_latch_strobe, program_store_strobe;
   logic ext_irq_two, timer2_count_in, program_store_strobe_seen, ale_seen, wait_request;
   logic [7:0] req_rdata, p0_out, p0_oe_n, p1_out, p1_oe_n, p2_out, p2_oe_n, p3_out, p3_oe_n, p1_pins;
   logic [3:0] p4_out, p4_oe_n;
   int err_total = 0, total_checks = 0, cyc = 0, n;
   int ns [4] = '{1, 2, 9, 15};
   int es [4] = '{2, 2, 9, 9};
   always #25 clk_sys = ~clk_sys;
   // Pulled-up pins read high unless driven low
   assign p1_in = p1_oe_n | p1_out;
   assign p2_in = p2_oe_n | p2_out;
   assign p3_in = p3_oe_n | p3_out;
   assign p4_in = (p4_oe_n | p4_out) & {3'h7, ~wait_low};
   ebpm_port_mux u_ebpm_port_mux (.clk_sys, .rst, .req_valid, .req_kind, .req_addr, .req_wdata, .req_done,
      .req_rdata, .movx_stretch, .sram_enable_wr, .sram_enable_val, .internal_sram_enable, .wait_enable,
      .p0_latch(8'hff), .p1_latch, .p2_latch(8'hff), .p3_latch(8'hff), .p4_latch(4'hf), .p0_in, .p0_out,
      .p0_oe_n, .p1_in, .p1_out, .p1_oe_n, .p2_in, .p2_out, .p2_oe_n, .p3_in, .p3_out, .p3_oe_n, .p4_in,
      .p4_out, .p4_oe_n, .address_latch_strobe, .program_store_strobe, .p0_pins(), .p1_pins, .p2_pins(),
      .p3_pins(), .p4_pins(), .timer2_count_in, .timer2_reload_capture_in(), .serial_b_receive(),
      .ext_irq_two, .ext_irq_three(), .ext_irq_four(), .ext_irq_five(), .serial_a_receive(),
      .ext_irq_zero(), .ext_irq_one(), .timer_zero_ext_in(), .timer_one_ext_in(), .wait_request,
      .serial_a_transmit, .serial_b_transmit);
   ebpm_ext_mem u_ebpm_ext_mem (.clk_sys, .p0_out, .p0_oe_n, .p2_in, .p3_oe_n, .address_latch_strobe,
      .program_store_strobe, .p0_in);
   always @(posedge clk_sys) begin
      cyc++;
      if (!program_store_strobe) program_store_strobe_seen = 1'b1;
      if (address_latch_strobe) ale_seen = 1'b1;
      if (cyc == 5000) begin
         err_total++;
         close_out();
      end
   end
   task automatic req(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      {req_kind, req_addr, req_wdata, req_valid} = {k, a, d, 1'b1};
      program_store_strobe_seen = 1'b0;
      ale_seen = 1'b0;
      @(posedge clk_sys);
      @(negedge clk_sys);
      req_valid = 1'b0;
      n = 0;
      do begin
         @(posedge clk_sys);
         #1 n++;
      end while (req_done !== 1'b1 && n < 100);
   endtask : req
   task automatic set_sram(input logic v);
      @(negedge clk_sys);
      {sram_enable_wr, sram_enable_val} = {1'b1, v};
      @(negedge clk_sys);
      sram_enable_wr = 1'b0;
   endtask : set_sram
   task automatic t_reset();
      @(negedge clk_sys);
      rst = 1'b1;
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      `CHK(p0_oe_n, 8'hff)
      `CHK({address_latch_strobe, program_store_strobe}, 2'h1)
      `CHK(internal_sram_enable, 1'b0)
      // Cleared enable sends the low window outside
      req(2'h3, 16'h03ff, 8'h11);
      `CHK(n, 11)
      `CHK(ale_seen, 1'b1)
   endtask : t_reset
   task automatic t_movx();
      for (int i = 0; i < 4; i++) begin
         movx_stretch = ns[i][3:0];
         req(2'h3, 16'h1234 + 16'(i), 8'ha5 ^ 8'(i));
         `CHK(n, 3 + 4 * es[i])
         `CHK(u_ebpm_ext_mem.addr_q, 16'h1234 + 16'(i))
         req(2'h2, 16'h1234 + 16'(i), 8'h00);
         `CHK(n, 3 + 4 * es[i])
         `CHK(req_rdata, 8'ha5 ^ 8'(i))
         `CHK({ale_seen, program_store_strobe_seen}, 2'h2)
      end
   endtask : t_movx
   task automatic t_sram();
      movx_stretch = 4'h2;
      set_sram(1'b1);
      `CHK(internal_sram_enable, 1'b1)
      req(2'h3, 16'h03ff, 8'h3c);
      `CHK({n, ale_seen}, {32'd5, 1'b0})
      req(2'h2, 16'h03ff, 8'h00);
      `CHK(req_rdata, 8'h3c)
      req(2'h3, 16'h0400, 8'h4b);
      `CHK({n, ale_seen}, {32'd11, 1'b1})
      `CHK(u_ebpm_ext_mem.mem[16'h0400], 8'h4b)
   endtask : t_sram
   task automatic t_fetch();
      movx_stretch = 4'h9;
      for (int k = 0; k < 2; k++) begin
         req(2'(k), 16'h1234, 8'h00);
         `CHK({n, program_store_strobe_seen}, {32'd7, 1'b1})
         `CHK(req_rdata, 8'ha5)
      end
   endtask : t_fetch
   task automatic t_wait();
      movx_stretch = 4'h2;
      wait_enable = 1'b1;
      fork
         req(2'h3, 16'h2000, 8'h77);
         begin
            repeat (4) @(negedge clk_sys);
            wait_low = 1'b1;
            repeat (4) @(negedge clk_sys);
            `CHK(wait_request, 1'b1)
            wait_low = 1'b0;
         end
      join
      `CHK(n, 15)
      `CHK(u_ebpm_ext_mem.mem[16'h2000], 8'h77)
      wait_enable = 1'b0;
   endtask : t_wait
   task automatic t_port();
      @(negedge clk_sys);
      p1_latch = 8'h5a;
      serial_a_transmit = 1'b0;
      serial_b_transmit = 1'b0;
      repeat (4) @(negedge clk_sys);
      `CHK(p1_oe_n, 8'h52)
      `CHK(p1_pins, 8'h52)
      `CHK({ext_irq_two, timer2_count_in}, 2'h2)
      `CHK(p3_oe_n[1], 1'b0)
      p1_latch = 8'hff;
      serial_a_transmit = 1'b1;
      serial_b_transmit = 1'b1;
   endtask : t_port
   task automatic close_out();
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out
   initial begin
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      t_movx();
      t_sram();
      t_reset();
      t_fetch();
      t_wait();
      t_port();
      close_out();
   end
endmodule : test_external_bus_port_mux
